// ==== hw/pccs_pkg.sv ====
// Package for the configuration command/status register bank.
// Assumes a single clk_sys domain with synchronous active-high reset.
package pccs_pkg;

  // Register addresses (byte offsets within configuration space)
  localparam logic [7:0] PCCS_OFF_COMMAND = 8'h04;
  localparam logic [7:0] PCCS_OFF_STATUS = 8'h06;
  localparam logic [7:0] PCCS_OFF_IRQ_MASK = 8'h40;
  localparam logic [7:0] PCCS_OFF_PAR_RESP = 8'h44;

  // Command register bit positions
  localparam int PCCS_CMD_IO_BIT = 0;
  localparam int PCCS_CMD_MEM_BIT = 1;
  localparam int PCCS_CMD_MASTER_BIT = 2;
  localparam int PCCS_CMD_PARRESP_BIT = 6;

  // Status register bit positions
  localparam int PCCS_ST_CAP_BIT = 4;
  localparam int PCCS_ST_FAST66_BIT = 5;
  localparam int PCCS_ST_B2B_BIT = 7;
  localparam int PCCS_ST_MASTER_PARITY_ERROR_BIT = 8;
  localparam int PCCS_ST_SELT_LO = 9;
  localparam int PCCS_ST_STA_BIT = 11;
  localparam int PCCS_ST_RTA_BIT = 12;
  localparam int PCCS_ST_RMA_BIT = 13;
  localparam int PCCS_ST_SSE_BIT = 14;
  localparam int PCCS_ST_DPE_BIT = 15;

  // Reset values
  localparam logic [15:0] PCCS_CMD_RESET = 16'h0000;
  localparam logic [15:0] PCCS_MASK_RESET = 16'h0000;

  // Select timing encodings
  localparam logic [1:0] PCCS_SELT_FAST = 2'h0;
  localparam logic [1:0] PCCS_SELT_MEDIUM = 2'h1;
  localparam logic [1:0] PCCS_SELT_SLOW = 2'h2;

  // Mask of the sticky event bits in the status register
  localparam logic [15:0] PCCS_EVENT_MASK = 16'hF900;

  // Bus events reported by the surrounding PCI logic
  typedef struct packed {
    logic parity_detect;
    logic serr_driven;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
    logic perr_master;
  } pccs_event_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pccs_req_s;

endpackage : pccs_pkg

// ==== hw/pccs_sticky.sv ====
// Sticky status bit set by a hardware event, cleared by writing one.
// Assumes event and clear come from the clk_sys domain.
`timescale 1ns/10ps
module pccs_sticky (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic set_evt,
  input wire logic clr,
  output logic flag
);

  wire next_flag = set_evt | (flag & ~clr);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : pccs_sticky

// ==== hw/pccs_regs.sv ====
// Configuration command and status registers of a PCI function.
// Assumes the PCI engine reports bus events as one-cycle pulses on
// clk_sys, and register access over a simple strobe port.
//
// Functional notes
// [RL1] master_enable at one allows starting initiator transactions.
// [RL2] mem_decode_enable resets to zero; one allows claiming memory accesses.
// [RL3] io_decode_enable, bit 0, resets to zero; one allows claiming I/O.
// [RL4] Sixteen-bit status register at offset 06h, read-only to software; here the event bits clear on writing one.
// [RL5] select_timing field: 00b fast, 01b medium; this device reports medium.
// [RL6] parity_error_seen, bit 15, set on any parity error, regardless.
// [RL7] sys_error_signaled, bit 14, set whenever SERR# is driven.
// [RL8] got_master_abort, bit 13, set on own non-special-cycle master abort.
// [RL9] got_target_abort, bit 12, set when target aborts own transaction.
// [RL10] sent_target_abort, bit 11, set when this target signals abort.
// [RL11] select_timing 10b slow, 11b reserved; read-only slowest timing.
// [RL12] master_parity_error set only as initiator with parity_response set.
// [RL13] Reserved status bits read zero; cap_list_present reads one.
`timescale 1ns/10ps
module pccs_regs
  import pccs_pkg::*;
#(
  parameter logic [1:0] SELECT_TIMING = PCCS_SELT_MEDIUM,
  parameter logic BACK_TO_BACK = 1'b0,
  parameter logic FAST_CLOCK = 1'b0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic evt_parity_detect,
  input wire logic evt_serr_driven,
  input wire logic evt_master_abort,
  input wire logic evt_master_special,
  input wire logic evt_target_abort_rx,
  input wire logic evt_target_abort_tx,
  input wire logic evt_perr_self_read,
  input wire logic evt_perr_seen_write,
  input wire logic evt_as_master,
  output logic master_enable,
  output logic mem_decode_enable,
  output logic io_decode_enable,
  output logic parity_response,
  output logic irq
);

  logic [15:0] command;
  logic [15:0] irq_mask;
  logic [15:0] status;
  logic [15:0] next_rdata;
  pccs_req_s req;
  pccs_event_s evt;
  logic [5:0] flag;
  logic [5:0] evt_vec;
  logic [5:0] clr_vec;

  // Enable outputs track the command register value with no lag
  function automatic logic next_enable(input logic wr,
                                       input logic [15:0] nv,
                                       input logic [15:0] cv,
                                       input int pos);
    next_enable = wr ? nv[pos] : cv[pos];
  endfunction : next_enable

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Address decode
  wire hit_cmd = req.addr == PCCS_OFF_COMMAND;
  wire hit_status = req.addr == PCCS_OFF_STATUS;
  wire hit_mask = req.addr == PCCS_OFF_IRQ_MASK;
  wire wr_cmd = req.wr & hit_cmd;
  wire wr_status = req.wr & hit_status;
  wire wr_mask = req.wr & hit_mask;

  // Event qualification
  assign evt = '{
    parity_detect: evt_parity_detect, // [RL6]
    serr_driven: evt_serr_driven, // [RL7]
    master_abort: evt_master_abort & ~evt_master_special, // [RL8]
    target_abort_rx: evt_target_abort_rx, // [RL9]
    target_abort_tx: evt_target_abort_tx, // [RL10]
    // Both the own-read and seen-write cases need master role and enable
    perr_master: evt_as_master & parity_response &
                 (evt_perr_self_read | evt_perr_seen_write) // [RL12]
  };

  assign evt_vec = {evt.parity_detect, evt.serr_driven, evt.master_abort,
                    evt.target_abort_rx, evt.target_abort_tx,
                    evt.perr_master};

  // Write-one-to-clear on the status word; set wins over clear
  assign clr_vec = wr_status ? {req.wdata[PCCS_ST_DPE_BIT],
                                req.wdata[PCCS_ST_SSE_BIT],
                                req.wdata[PCCS_ST_RMA_BIT],
                                req.wdata[PCCS_ST_RTA_BIT],
                                req.wdata[PCCS_ST_STA_BIT],
                                req.wdata[PCCS_ST_MASTER_PARITY_ERROR_BIT]} : 6'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      pccs_sticky u_flag (
        .clk_sys(clk_sys),
        .srst(srst),
        .set_evt(evt_vec[gi]),
        .clr(clr_vec[gi]),
        .flag(flag[gi])
      );
    end
  endgenerate

  // Status word assembly; reserved bits are constant zero
  always_comb begin
    status = 16'h0000; // [RL13]
    status[PCCS_ST_DPE_BIT] = flag[5]; // [RL6]
    status[PCCS_ST_SSE_BIT] = flag[4]; // [RL7]
    status[PCCS_ST_RMA_BIT] = flag[3]; // [RL8]
    status[PCCS_ST_RTA_BIT] = flag[2]; // [RL9]
    status[PCCS_ST_STA_BIT] = flag[1]; // [RL10]
    status[PCCS_ST_MASTER_PARITY_ERROR_BIT] = flag[0]; // [RL12]
    // Fixed timing code, never the reserved 11b
    status[PCCS_ST_SELT_LO +: 2] =
      (SELECT_TIMING == 2'h3) ? PCCS_SELT_SLOW : SELECT_TIMING; // [RL5] [RL11]
    status[PCCS_ST_B2B_BIT] = BACK_TO_BACK;
    status[PCCS_ST_FAST66_BIT] = FAST_CLOCK;
    status[PCCS_ST_CAP_BIT] = 1'b1; // [RL13]
  end

  // Only the implemented command bits are writable
  localparam logic [15:0] CMD_WMASK = 16'h0047;
  wire [15:0] next_command = (req.wdata & CMD_WMASK);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      command <= PCCS_CMD_RESET; // [RL2] [RL3]
      irq_mask <= PCCS_MASK_RESET;
    end else begin
      if (wr_cmd) begin
        command <= next_command;
      end
      if (wr_mask) begin
        irq_mask <= req.wdata & PCCS_EVENT_MASK;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 16'h0000;
    if (hit_cmd) begin
      next_rdata = command;
    end else if (hit_status) begin
      next_rdata = status; // [RL4]
    end else if (hit_mask) begin
      next_rdata = irq_mask;
    end
  end

  wire next_irq = |(status & irq_mask & PCCS_EVENT_MASK);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
      master_enable <= 1'b0;
      mem_decode_enable <= 1'b0;
      io_decode_enable <= 1'b0;
      parity_response <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= req.rd ? next_rdata : 16'h0000;
      master_enable <= next_enable(wr_cmd, next_command, command,
                                   PCCS_CMD_MASTER_BIT); // [RL1]
      mem_decode_enable <= next_enable(wr_cmd, next_command, command,
                                       PCCS_CMD_MEM_BIT); // [RL2]
      io_decode_enable <= next_enable(wr_cmd, next_command, command,
                                      PCCS_CMD_IO_BIT); // [RL3]
      parity_response <= next_enable(wr_cmd, next_command, command,
                                     PCCS_CMD_PARRESP_BIT);
      irq <= next_irq;
    end
  end

endmodule : pccs_regs

// ==== test/pccs_props.sv ====
// Port checker for the command/status register bank.
// Assumes it is bound into pccs_regs and sees its ports by name.
`timescale 1ns/10ps
module pccs_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic evt_parity_detect,
  input wire logic evt_serr_driven,
  input wire logic evt_master_abort,
  input wire logic evt_master_special,
  input wire logic evt_target_abort_rx,
  input wire logic evt_target_abort_tx,
  input wire logic evt_perr_self_read,
  input wire logic evt_perr_seen_write,
  input wire logic evt_as_master,
  input wire logic master_enable,
  input wire logic mem_decode_enable,
  input wire logic io_decode_enable,
  input wire logic parity_response,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Implemented command bits as written: parity response, then 2..0
  logic [3:0] cmd_low;
  assign cmd_low = {reg_wdata[6], reg_wdata[2:0]};
  sequence s_rd_st;
    reg_rd && reg_addr == 8'h06;
  endsequence
  sequence s_wr_cmd;
    reg_wr && reg_addr == 8'h04;
  endsequence
  sequence s_perr_mst;
    evt_as_master && parity_response &&
      (evt_perr_self_read || evt_perr_seen_write);
  endsequence
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_fixed_fields: assert property (
    s_rd_st |=> reg_rdata[7:0] == 8'h10 && reg_rdata[10:9] == 2'b01)
    else $error("fixed status bits wrong");
  a_parity_flag: assert property (
    evt_parity_detect ##1 s_rd_st |=> reg_rdata[15])
    else $error("parity flag missing");
  a_serr_flag: assert property (
    evt_serr_driven ##1 s_rd_st |=> reg_rdata[14])
    else $error("system error flag missing");
  a_mabort_flag: assert property (
    evt_master_abort && !evt_master_special ##1 s_rd_st |=> reg_rdata[13])
    else $error("master abort flag missing");
  a_tabort_rx: assert property (
    evt_target_abort_rx ##1 s_rd_st |=> reg_rdata[12])
    else $error("received abort flag missing");
  a_tabort_tx: assert property (
    evt_target_abort_tx ##1 s_rd_st |=> reg_rdata[11])
    else $error("sent abort flag missing");
  a_cmd_update: assert property (
    s_wr_cmd |=> {parity_response, master_enable, mem_decode_enable,
      io_decode_enable} == $past(cmd_low))
    else $error("command enables not updated");
  a_master_parity_error_flag: assert property (
    s_perr_mst ##1 s_rd_st |=> reg_rdata[8])
    else $error("master parity flag missing");
endmodule : pccs_props

// ==== test/pccs_engine_model.sv ====
// Far-side PCI engine: turns one-cycle requests into event pulses.
// Assumes requests arrive on clk_sys.
`timescale 1ns/10ps
module pccs_engine_model (
  input wire logic clk_sys,
  input wire logic [6:0] fire,
  output logic [6:0] evt
);
  // Each bus event is reported as one single-cycle pulse
  always_ff @(posedge clk_sys) begin
    evt <= fire;
  end
endmodule : pccs_engine_model

// ==== test/test_pci_config_command_status.sv ====
// Testbench for the command/status register bank.
// Assumes pccs_regs, the engine model and the checker are compiled first.
`timescale 1ns/10ps
module test_pci_config_command_status import pccs_pkg::*;;
  logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic evt_as_master = 1'b0, evt_master_special = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [6:0] fire = 7'h00, evt;
  logic master_enable, mem_decode_enable, io_decode_enable;
  logic parity_response, irq;
  int n_fail = 0, n_tests = 0;
  wire [15:0] en_v = {12'h000, parity_response, master_enable,
    mem_decode_enable, io_decode_enable};
  always #4 clk_sys = ~clk_sys;
  pccs_engine_model eng (.clk_sys(clk_sys), .fire(fire), .evt(evt));
  pccs_regs uut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .evt_parity_detect(evt[0]),
    .evt_serr_driven(evt[1]), .evt_master_abort(evt[2]),
    .evt_master_special(evt_master_special),
    .evt_target_abort_rx(evt[3]), .evt_target_abort_tx(evt[4]),
    .evt_perr_self_read(evt[5]), .evt_perr_seen_write(evt[6]),
    .evt_as_master(evt_as_master), .master_enable(master_enable),
    .mem_decode_enable(mem_decode_enable),
    .io_decode_enable(io_decode_enable),
    .parity_response(parity_response), .irq(irq));
  task chk(input string nm, input logic [15:0] e, s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask : rd
  task pulse(input logic [6:0] m);
    @(posedge clk_sys) fire <= m;
    @(posedge clk_sys) fire <= 7'h00;
  endtask : pulse
  task t_reset;
    rd(8'h06, 16'h0210, "status reset");
    rd(8'h04, 16'h0000, "command reset");
    chk("enables reset", 16'h0000, en_v);
    rd(8'h44, 16'h0000, "unmapped");
  endtask : t_reset
  task t_cmd;
    wr(8'h04, 16'hFFFF);
    #1 chk("enables on", 16'h000F, en_v);
    rd(8'h04, 16'h0047, "command bits");
    wr(8'h04, 16'h0002);
    #1 chk("memory only", 16'h0002, en_v);
    wr(8'h04, 16'h0040);
  endtask : t_cmd
  task t_events;
    for (int i = 0; i < 5; i++) begin
      pulse(7'h01 << i);
      rd(8'h06, 16'h0210 | (16'h8000 >> i), "event flag");
      wr(8'h06, 16'h8000 >> i);
      rd(8'h06, 16'h0210, "flag cleared");
    end
    @(posedge clk_sys) evt_master_special <= 1'b1;
    pulse(7'h04);
    rd(8'h06, 16'h0210, "special cycle");
    @(posedge clk_sys) evt_master_special <= 1'b0;
    wr(8'h06, 16'h06FF);
    rd(8'h06, 16'h0210, "fixed bits");
  endtask : t_events
  task t_master_parity_error;
    pulse(7'h20);
    rd(8'h06, 16'h0210, "perr as target");
    @(posedge clk_sys) evt_as_master <= 1'b1;
    pulse(7'h40);
    rd(8'h06, 16'h0310, "perr as master");
    wr(8'h06, 16'h0100);
    wr(8'h04, 16'h0000);
    pulse(7'h20);
    rd(8'h06, 16'h0210, "perr no response");
    @(posedge clk_sys) evt_as_master <= 1'b0;
  endtask : t_master_parity_error
  task t_rst_mid;
    wr(8'h40, 16'h8000);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq parity", 16'h0001, {15'h0000, irq});
    @(posedge clk_sys) srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1 chk("irq after reset", 16'h0000, {15'h0000, irq});
    rd(8'h06, 16'h0210, "status after reset");
    rd(8'h40, 16'h0000, "mask after reset");
    rd(8'h04, 16'h0000, "command after reset");
  endtask : t_rst_mid
  task t_irq;
    wr(8'h40, 16'h4000);
    pulse(7'h02);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq set", 16'h0001, {15'h0000, irq});
    wr(8'h06, 16'h4000);
    pulse(7'h01);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq masked", 16'h0000, {15'h0000, irq});
  endtask : t_irq
  task close_out;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_cmd;
    t_events;
    t_master_parity_error;
    t_irq;
    t_rst_mid;
    close_out;
  end
  initial begin
    #100000;
    n_fail++;
    close_out;
  end
endmodule : test_pci_config_command_status
bind pccs_regs pccs_props chk_i (.clk_sys(clk_sys), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .evt_parity_detect(evt_parity_detect), .evt_serr_driven(evt_serr_driven),
  .evt_master_abort(evt_master_abort),
  .evt_master_special(evt_master_special),
  .evt_target_abort_rx(evt_target_abort_rx),
  .evt_target_abort_tx(evt_target_abort_tx),
  .evt_perr_self_read(evt_perr_self_read),
  .evt_perr_seen_write(evt_perr_seen_write),
  .evt_as_master(evt_as_master), .master_enable(master_enable),
  .mem_decode_enable(mem_decode_enable),
  .io_decode_enable(io_decode_enable),
  .parity_response(parity_response), .irq(irq));
